// file: src/gsms_dev.sv
/*
  Sensor end of the mode sequencer: holds the control fields, decodes
  the mode field and runs the measurement periods.
  Assumes the host end on the same clock drives the write strobe.
*/
`timescale 1ns/1ps
`include "gsms_consts.svh"

module gsms_dev #(
  parameter logic [31:0] CYC_PER_MS = `GSMS_CYC_PER_MS, // Clock cycles per millisecond
  parameter logic [31:0] CONV_CYC = `GSMS_CONV_CYC, // Cycles per single sample
  parameter logic [31:0] GAS_CONV_CYC = `GSMS_GAS_CONV_CYC // Cycles per gas conversion
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  gsms_if.dev bus,
  output logic [1:0] mode_o,
  output logic busy_o,
  output logic heater_on_o,
  output logic [7:0] heater_code_o,
  output logic [3:0] step_idx_o,
  output logic gas_conv_o,
  output logic cycle_done_o
);
  import gsms_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Oversampling code to ratio; codes above 16x read as 16x
  function automatic logic [31:0] osr_ratio(input logic [2:0] code);
    logic [31:0] r;
    r = 32'h0;
    if (code >= `GSMS_OSR_16X)
      r = 32'h10;
    else if (code != `GSMS_OSR_RST)
      r = 32'h1 << (code - `GSMS_OSR_1X);
    return r;
  endfunction

  // Duration code: low six bits of ms times 1, 4, 16 or 64
  function automatic logic [31:0] heat_cyc(input logic [7:0] code);
    logic [31:0] ms;
    ms = {26'h0, code[5:0]} << {code[7:6], 1'b0};
    return 32'(ms * CYC_PER_MS);
  endfunction

  // Step index kept inside the ten stored pairs
  function automatic logic [3:0] clamp_step(input logic [3:0] s);
    return (s > `GSMS_LAST_STEP) ? `GSMS_LAST_STEP : s;
  endfunction

  // Opens a measurement period with the current settings
  function automatic gsms_dev_s start_period(input gsms_dev_s s);
    gsms_dev_s r;
    r = s;
    r.active = 1'b1;
    r.tph = TPH_T;
    r.tph_cnt = 32'h0;
    r.gas_cnt = 32'h0;
    if (!s.run_gas)
      r.gas = GAS_DONE;
    else if (s.mode == GSMS_PARALLEL)
      r.gas = GAS_HEAT;
    else
      r.gas = GAS_IDLE;
    return r;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  gsms_dev_s q; // Registered state
  gsms_dev_s d; // Next state
  logic [2:0] cur_osr; // Oversampling of the running sub-measurement
  logic [3:0] wr_step; // Step index addressed by a write
  logic wr_step_ok; // Write address hits a stored step

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    d = q;
    d.done = 1'b0;
    wr_step = bus.wr_addr[3:0];
    wr_step_ok = (wr_step <= `GSMS_LAST_STEP);
    // Oversampling of the sub-measurement in progress
    unique case (q.tph)
      TPH_T: cur_osr = q.osr_t;
      TPH_P: cur_osr = q.osr_p;
      TPH_H: cur_osr = q.osr_h;
      TPH_DONE: cur_osr = `GSMS_OSR_RST;
    endcase
    if (q.active)
    begin
      // Temperature, pressure, humidity in turn; ratio zero costs one cycle
      if (q.tph != TPH_DONE)
      begin
        if (q.tph_cnt >= 32'(osr_ratio(cur_osr) * CONV_CYC))
        begin
          d.tph = gsms_tph_e'(q.tph + 2'h1);
          d.tph_cnt = 32'h0;
        end
        else
          d.tph_cnt = q.tph_cnt + 32'h1;
      end
      // Gas heater and conversion
      unique case (q.gas)
        GAS_IDLE:
        begin
          // Forced: heater waits for the last TPH conversion
          if (q.tph == TPH_DONE)
            d.gas = GAS_HEAT;
        end
        GAS_HEAT:
        begin
          // Plate held at temperature for the coded time
          if (q.gas_cnt >= heat_cyc(q.gas_wait[q.idx]))
          begin
            d.gas = GAS_CONV;
            d.gas_cnt = 32'h0;
          end
          else
            d.gas_cnt = q.gas_cnt + 32'h1;
        end
        GAS_CONV:
        begin
          if (q.gas_cnt >= GAS_CONV_CYC)
            d.gas = GAS_DONE;
          else
            d.gas_cnt = q.gas_cnt + 32'h1;
        end
        GAS_DONE:
        begin
          d.gas = GAS_DONE;
        end
      endcase
      // End of period: both halves finished
      if (q.tph == TPH_DONE && q.gas == GAS_DONE)
      begin
        d.active = 1'b0;
        d.done = 1'b1;
        if (q.mode == GSMS_FORCED && !q.pend)
          d.mode = GSMS_SLEEP;
        else if (q.mode == GSMS_PARALLEL && !q.pend)
        begin
          // Next step up to the select field, then wrap to step zero
          if (q.idx >= clamp_step(q.step_sel))
            d.idx = 4'h0;
          else
            d.idx = q.idx + 4'h1;
          d = start_period(d);
        end
      end
    end
    else if (q.pend)
    begin
      // Pending mode executes only once no period runs
      d.pend = 1'b0;
      d.mode = q.pend_mode;
      d.idx = (q.pend_mode == GSMS_FORCED) ? clamp_step(q.step_sel) : 4'h0;
      if (q.pend_mode != GSMS_SLEEP)
        d = start_period(d);
    end
    // Control field writes; all dropped while a mode change pends
    if (bus.wr_en && !q.pend)
    begin
      if (bus.wr_addr == `GSMS_ADDR_MODE)
      begin
        // Code 11 has no meaning and is ignored
        if (bus.wr_data[1:0] != 2'h3)
        begin
          d.pend = 1'b1;
          d.pend_mode = gsms_mode_e'(bus.wr_data[1:0]);
        end
      end
      else if (bus.wr_addr == `GSMS_ADDR_OSRH)
        d.osr_h = bus.wr_data[2:0];
      else if (bus.wr_addr == `GSMS_ADDR_OSRTP)
      begin
        d.osr_t = bus.wr_data[`GSMS_OSRTP_T_LSB +: 3];
        d.osr_p = bus.wr_data[`GSMS_OSRTP_P_LSB +: 3];
      end
      else if (bus.wr_addr == `GSMS_ADDR_GASCTL)
      begin
        d.run_gas = bus.wr_data[`GSMS_GASCTL_RUN_BIT];
        d.step_sel = bus.wr_data[3:0];
      end
      else if (bus.wr_addr[7:4] == `GSMS_ADDR_WAIT_HI && wr_step_ok)
        d.gas_wait[wr_step] = bus.wr_data;
      else if (bus.wr_addr[7:4] == `GSMS_ADDR_RES_HI && wr_step_ok)
        d.res_heat[wr_step] = bus.wr_data;
    end
  end

  // ----------------------------------------------------------------
  // State register; reset lands in sleep with nothing running
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
      q.mode <= GSMS_SLEEP;
      q.pend_mode <= GSMS_SLEEP;
      q.tph <= TPH_DONE;
      q.gas <= GAS_DONE;
    end
    else if (ce_i)
      q <= d;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign bus.busy = q.active;
  assign bus.pend = q.pend;
  assign bus.mode = q.mode;
  assign mode_o = q.mode;
  assign busy_o = q.active;
  // Heater powered in heating and gas conversion only
  assign heater_on_o = q.active && (q.gas == GAS_HEAT || q.gas == GAS_CONV);
  // Resistance code goes to the plate driver as stored
  assign heater_code_o = q.res_heat[q.idx];
  assign step_idx_o = q.idx;
  assign gas_conv_o = q.active && q.gas == GAS_CONV;
  assign cycle_done_o = q.done;

endmodule

// file: src/gsms_consts.svh
/*
  Shared constants of the gas sensor mode sequencer: write addresses,
  field positions, mode codes, reset values and timing counts.
  Assumes it is included by bare name from the package and both ends.
*/
`ifndef GSMS_CONSTS_SVH
`define GSMS_CONSTS_SVH

// ----------------------------------------------------------------
// Control field write addresses
// ----------------------------------------------------------------
`define GSMS_ADDR_MODE 8'h00
`define GSMS_ADDR_OSRH 8'h01
`define GSMS_ADDR_OSRTP 8'h02
`define GSMS_ADDR_GASCTL 8'h03
`define GSMS_ADDR_WAIT_HI 4'h1
`define GSMS_ADDR_RES_HI 4'h2

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define GSMS_OSRTP_T_LSB 5
`define GSMS_OSRTP_P_LSB 2
`define GSMS_GASCTL_RUN_BIT 4

// ----------------------------------------------------------------
// Mode codes and sizes
// ----------------------------------------------------------------
`define GSMS_MODE_SLEEP 2'h0
`define GSMS_MODE_FORCED 2'h1
`define GSMS_MODE_PARALLEL 2'h2
`define GSMS_NUM_STEPS 10
`define GSMS_LAST_STEP 4'h9
`define GSMS_OSR_RST 3'h0
`define GSMS_OSR_1X 3'h1
`define GSMS_OSR_16X 3'h5
`define GSMS_BYTE_RST 8'h00

// ----------------------------------------------------------------
// Timing: clock rate, millisecond unit, conversion lengths
// ----------------------------------------------------------------
`define GSMS_CLK_HZ 100000000
`define GSMS_MS_PER_S 1000
`define GSMS_CYC_PER_MS (`GSMS_CLK_HZ / `GSMS_MS_PER_S)
`define GSMS_CONV_CYC 16
`define GSMS_GAS_CONV_CYC 64

`endif

// file: src/gsms_pkg.sv
/*
  Types of the gas sensor mode sequencer: modes, phase states and the
  packed state records of both ends.
  Assumes gsms_consts.svh is on the include path.
*/
`include "gsms_consts.svh"

package gsms_pkg;

  // ----------------------------------------------------------------
  // Operating modes as written to the mode field
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    GSMS_SLEEP = `GSMS_MODE_SLEEP,
    GSMS_FORCED = `GSMS_MODE_FORCED,
    GSMS_PARALLEL = `GSMS_MODE_PARALLEL
  } gsms_mode_e;

  // Temperature, pressure, humidity conversion phase
  typedef enum logic [1:0] {TPH_T, TPH_P, TPH_H, TPH_DONE} gsms_tph_e;

  // Gas heater and conversion phase
  typedef enum logic [1:0] {GAS_IDLE, GAS_HEAT, GAS_CONV, GAS_DONE} gsms_gas_e;

  // Host programming sequence
  typedef enum logic [2:0] {
    H_IDLE, H_WAIT, H_OSRH, H_OSRTP, H_WAITX, H_RESX, H_GASCTL, H_MODE
  } gsms_host_st_e;

  // Heater step table
  typedef logic [`GSMS_NUM_STEPS-1:0][7:0] gsms_steps_t;

  // ----------------------------------------------------------------
  // Device state record
  // ----------------------------------------------------------------
  typedef struct packed {
    gsms_mode_e mode;
    logic pend;
    gsms_mode_e pend_mode;
    logic [2:0] osr_t;
    logic [2:0] osr_p;
    logic [2:0] osr_h;
    logic run_gas;
    logic [3:0] step_sel;
    gsms_steps_t gas_wait;
    gsms_steps_t res_heat;
    logic active;
    gsms_tph_e tph;
    gsms_gas_e gas;
    logic [31:0] tph_cnt;
    logic [31:0] gas_cnt;
    logic [3:0] idx;
    logic done;
  } gsms_dev_s;

  // ----------------------------------------------------------------
  // Host state record
  // ----------------------------------------------------------------
  typedef struct packed {
    gsms_host_st_e st;
    logic [3:0] idx;
    logic [3:0] nsteps;
    gsms_mode_e mode;
    logic [2:0] osr_t;
    logic [2:0] osr_p;
    logic [2:0] osr_h;
    logic run_gas;
    logic [3:0] step_sel;
    gsms_steps_t gas_wait;
    gsms_steps_t res_heat;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic done;
  } gsms_host_s;

endpackage

// file: src/gsms_if.sv
/*
  Carrier between the host end and the sensor end: a one-cycle write
  strobe with address and data, and the sensor's mode status back.
  Assumes both ends share one clock, so nothing here is synchronised.
*/
`timescale 1ns/1ps

interface gsms_if;
  logic wr_en; // One-cycle write strobe
  logic [7:0] wr_addr; // Control field address
  logic [7:0] wr_data; // Write data
  logic busy; // Measurement period running
  logic pend; // Mode change accepted, not yet executed
  logic [1:0] mode; // Mode now in force

  // Sensor end
  modport dev (
    input wr_en,
    input wr_addr,
    input wr_data,
    output busy,
    output pend,
    output mode
  );

  // Host end
  modport host (
    output wr_en,
    output wr_addr,
    output wr_data,
    input busy,
    input pend,
    input mode
  );
endinterface

// file: src/gsms_host.sv
/*
  Host end of the mode sequencer: on a start request it programs the
  sensor's control fields in the recommended order and writes the
  mode field last.
  Assumes the sensor end on the same clock answers with pend status.
*/
`timescale 1ns/1ps
`include "gsms_consts.svh"

module gsms_host (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  gsms_if.host bus,
  input wire logic start_i,
  input wire logic [1:0] mode_i,
  input wire logic [2:0] osr_t_i,
  input wire logic [2:0] osr_p_i,
  input wire logic [2:0] osr_h_i,
  input wire logic run_gas_i,
  input wire logic [3:0] step_sel_i,
  input wire logic [3:0] nsteps_i,
  input wire gsms_pkg::gsms_steps_t gas_wait_i,
  input wire gsms_pkg::gsms_steps_t res_heat_i,
  output logic busy_o,
  output logic done_o
);
  import gsms_pkg::*;

  gsms_host_s q; // Registered state
  gsms_host_s d; // Next state

  // ----------------------------------------------------------------
  // Sequence of writes, one per cycle
  // ----------------------------------------------------------------
  always_comb
  begin
    d = q;
    d.wr_en = 1'b0;
    d.done = 1'b0;
    unique case (q.st)
      H_IDLE:
      begin
        if (start_i)
        begin
          d.mode = gsms_mode_e'(mode_i);
          d.osr_t = osr_t_i;
          d.osr_p = osr_p_i;
          d.osr_h = osr_h_i;
          d.run_gas = run_gas_i;
          d.step_sel = step_sel_i;
          d.gas_wait = gas_wait_i;
          d.res_heat = res_heat_i;
          d.idx = 4'h0;
          // At least one pair, at most ten
          if (nsteps_i == 4'h0)
            d.nsteps = 4'h1;
          else if (nsteps_i > 4'(`GSMS_NUM_STEPS))
            d.nsteps = 4'(`GSMS_NUM_STEPS);
          else
            d.nsteps = nsteps_i;
          // Parallel needs one of T, P, H; temperature is the fallback
          if (mode_i == `GSMS_MODE_PARALLEL && osr_t_i == `GSMS_OSR_RST &&
              osr_p_i == `GSMS_OSR_RST && osr_h_i == `GSMS_OSR_RST)
            d.osr_t = `GSMS_OSR_1X;
          d.st = H_WAIT;
        end
      end
      H_WAIT:
      begin
        // Writes during a pending mode change would be lost
        if (!bus.pend)
          d.st = H_OSRH;
      end
      H_OSRH:
      begin
        // Humidity first
        d.wr_en = 1'b1;
        d.wr_addr = `GSMS_ADDR_OSRH;
        d.wr_data = {5'h0, q.osr_h};
        d.st = H_OSRTP;
      end
      H_OSRTP:
      begin
        // Temperature and pressure in one write
        d.wr_en = 1'b1;
        d.wr_addr = `GSMS_ADDR_OSRTP;
        d.wr_data = {q.osr_t, q.osr_p, 2'h0};
        d.st = H_WAITX;
      end
      H_WAITX:
      begin
        d.wr_en = 1'b1;
        d.wr_addr = {`GSMS_ADDR_WAIT_HI, q.idx};
        d.wr_data = q.gas_wait[q.idx];
        d.st = H_RESX;
      end
      H_RESX:
      begin
        // Code is written as supplied by the user
        d.wr_en = 1'b1;
        d.wr_addr = {`GSMS_ADDR_RES_HI, q.idx};
        d.wr_data = q.res_heat[q.idx];
        d.idx = q.idx + 4'h1;
        d.st = (q.idx + 4'h1 >= q.nsteps) ? H_GASCTL : H_WAITX;
      end
      H_GASCTL:
      begin
        d.wr_en = 1'b1;
        d.wr_addr = `GSMS_ADDR_GASCTL;
        d.wr_data = {3'h0, q.run_gas, q.step_sel};
        d.st = H_MODE;
      end
      H_MODE:
      begin
        // Mode goes last, after every other field
        d.wr_en = 1'b1;
        d.wr_addr = `GSMS_ADDR_MODE;
        d.wr_data = {6'h0, q.mode};
        d.done = 1'b1;
        d.st = H_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
      q.st <= H_IDLE;
      q.mode <= GSMS_SLEEP;
    end
    else if (ce_i)
      q <= d;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign bus.wr_en = q.wr_en;
  assign bus.wr_addr = q.wr_addr;
  assign bus.wr_data = q.wr_data;
  assign busy_o = (q.st != H_IDLE);
  assign done_o = q.done;

endmodule

// file: sim/gsms_assertions.sv
/*
  Checker on the carrier between the host end and the sensor end.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`include "gsms_consts.svh"

module gsms_assertions (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic busy,
  input wire logic pend,
  input wire logic [1:0] mode
);
  // ------
  // Clocking and sequences
  // ------
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  // Forced period reaching its end with no mode change waiting;
  // a waiting change keeps forced one more cycle, then executes
  sequence forced_end_s;
    mode == `GSMS_MODE_FORCED && busy && !pend ##1 !busy;
  endsequence

  // Mode write the sensor must take
  sequence mode_wr_s;
    wr_en && !pend && wr_addr == `GSMS_ADDR_MODE && wr_data[1:0] != 2'h3;
  endsequence

  // ------
  // Properties
  // ------
  reset_sleep_a: assert property ($fell(rst_i) |-> mode == `GSMS_MODE_SLEEP && !busy && !pend)
    else $error("state not cleared by reset");
  sleep_idle_a: assert property (mode == `GSMS_MODE_SLEEP && !pend |=> !busy)
    else $error("measurement started in sleep");
  mode_take_a: assert property (mode_wr_s |=> pend)
    else $error("mode write not taken");
  pend_hold_a: assert property (pend && busy |=> pend)
    else $error("mode change ran inside a period");
  pend_exec_a: assert property (pend && !busy |=> !pend)
    else $error("idle mode change not executed");
  exec_start_a: assert property ($fell(pend) |-> busy == (mode != `GSMS_MODE_SLEEP))
    else $error("mode decode wrong at execution");
  forced_back_a: assert property (forced_end_s |-> mode == `GSMS_MODE_SLEEP)
    else $error("forced did not return to sleep");
  parallel_stay_a: assert property (mode == `GSMS_MODE_PARALLEL && !pend |=> mode == `GSMS_MODE_PARALLEL)
    else $error("parallel left on its own");
  pend_quiet_a: assert property (pend |-> !wr_en)
    else $error("host wrote while pending");
  osr_order_a: assert property (wr_en && wr_addr == `GSMS_ADDR_OSRH |=> wr_en && wr_addr == `GSMS_ADDR_OSRTP)
    else $error("oversampling write order wrong");
  mode_last_a: assert property (wr_en && wr_addr == `GSMS_ADDR_GASCTL |=> wr_en && wr_addr == `GSMS_ADDR_MODE)
    else $error("mode not written last");
endmodule

// file: sim/gas_env_sensor_mode_sequencer_tb.sv
/*
  Bench: host end drives sensor end; a second sensor end is probed directly.
  Assumes the shared header is on the include path.
*/
`timescale 1ns/1ps
`include "gsms_consts.svh"

module gas_env_sensor_mode_sequencer_tb;
  import gsms_pkg::*;
  // Short counts keep the run brief
  localparam logic [31:0] CPM = 32'h2;
  localparam logic [31:0] CV = 32'h4;
  localparam logic [31:0] GC = 32'h8;
  logic mclk_i;
  logic rst_i;
  logic ce; // Held high, freeze is not probed
  logic start;
  logic [1:0] hmode;
  logic [2:0] ot, op, oh;
  logic run_gas;
  logic [3:0] sel, nst;
  gsms_steps_t gw, rh;
  logic hbusy, hdone, heat, gconv, cdone, cdone2, busy1;
  logic [1:0] mode1;
  logic [7:0] hcode;
  logic [3:0] sidx;
  logic [23:0] he;
  int fail_count = 0;
  int checks = 0;
  int pcnt = 0;
  int hcnt = 0;
  int gcnt = 0;
  int done2 = 0;
  logic [15:0] q_per[$]; // Forced period lengths, FFFF skips
  logic [23:0] q_heat[$]; // Step, code, heater cycles
  gsms_if bus ();
  gsms_if bus2 ();

  gsms_host gsms_host_inst (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce), .bus(bus), .start_i(start),
    .mode_i(hmode), .osr_t_i(ot), .osr_p_i(op), .osr_h_i(oh), .run_gas_i(run_gas), .step_sel_i(sel),
    .nsteps_i(nst), .gas_wait_i(gw), .res_heat_i(rh), .busy_o(hbusy), .done_o(hdone));
  gsms_dev #(.CYC_PER_MS(CPM), .CONV_CYC(CV), .GAS_CONV_CYC(GC)) gsms_dev_inst (.mclk_i(mclk_i),
    .rst_i(rst_i), .ce_i(ce), .bus(bus), .mode_o(mode1), .busy_o(busy1), .heater_on_o(heat),
    .heater_code_o(hcode), .step_idx_o(sidx), .gas_conv_o(gconv), .cycle_done_o(cdone));
  // Probe end, written by the bench out of turn
  gsms_dev #(.CYC_PER_MS(CPM), .CONV_CYC(CV), .GAS_CONV_CYC(GC)) gsms_dev_probe_inst (.mclk_i(mclk_i),
    .rst_i(rst_i), .ce_i(ce), .bus(bus2), .mode_o(), .busy_o(), .heater_on_o(), .heater_code_o(),
    .step_idx_o(), .gas_conv_o(), .cycle_done_o(cdone2));
  gsms_assertions gsms_assertions_inst (.mclk_i(mclk_i), .rst_i(rst_i), .wr_en(bus.wr_en),
    .wr_addr(bus.wr_addr), .wr_data(bus.wr_data), .busy(bus.busy), .pend(bus.pend), .mode(bus.mode));

  initial
  begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  // ------
  // Helpers
  // ------
  function automatic int ph(input logic [2:0] c);
    return (c == 3'h0 ? 0 : (c > 3'h5 ? 16 : 1 << (c - 1))) * CV + 1;
  endfunction
  function automatic int hl(input logic [7:0] c);
    return (int'(c[5:0]) << (2 * c[7:6])) * CPM + GC + 2;
  endfunction
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
      fail_count++;
    end
  endtask
  task automatic end_sim();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Host start pulse, then bounded wait for its last write
  task automatic run(input logic [1:0] m);
    int i;
    @(negedge mclk_i);
    hmode = m;
    start = 1'b1;
    @(negedge mclk_i);
    start = 1'b0;
    check("host busy", hbusy, 1'b1);
    for (i = 0; i < 100 && hdone !== 1'b1; i++)
      @(negedge mclk_i);
    check("host done", hdone, 1'b1);
    // Done and idle arrive together with the mode write
    check("host released", hbusy, 1'b0);
  endtask
  task automatic wait_idle();
    int i;
    repeat (3) @(negedge mclk_i);
    for (i = 0; i < 4000 && !(busy1 === 1'b0 && mode1 === 2'h0 && bus.pend === 1'b0); i++)
      @(negedge mclk_i);
    // A period that never ends counts as a mismatch here
    check("idle reached", {busy1, mode1, bus.pend}, 4'h0);
  endtask
  // Strobe held across calls so writes can be back to back
  task automatic wr2(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    bus2.wr_en = 1'b1;
    bus2.wr_addr = a;
    bus2.wr_data = d;
  endtask

  // ------
  // Monitors
  // ------
  // Period length and mode at each forced end
  always @(negedge mclk_i)
  begin
    if (busy1 === 1'b1)
      pcnt++;
    if (cdone2 === 1'b1)
      done2++;
    if (cdone === 1'b1)
    begin
      if (mode1 !== GSMS_PARALLEL)
      begin
        he[15:0] = q_per.size() ? q_per.pop_front() : 16'h0000;
        if (he[15:0] != 16'hFFFF)
          check("period cycles", pcnt, he[15:0]);
        check("mode after forced", mode1, GSMS_SLEEP);
      end
      pcnt = 0;
    end
  end
  // Heater step, code and on-time
  always @(negedge mclk_i)
  begin
    if (heat === 1'b1)
      hcnt++;
    if (gconv === 1'b1)
      gcnt++;
    if (heat === 1'b1 && hcnt == 1)
    begin
      check("step index", sidx, q_heat.size() ? q_heat[0][23:20] : 4'hF);
      check("heater code", hcode, q_heat.size() ? q_heat[0][19:12] : 8'hFF);
    end
    if (heat !== 1'b1 && hcnt > 0)
    begin
      check("heater cycles", hcnt, q_heat.size() ? q_heat.pop_front() & 24'hFFF : 0);
      check("conversion cycles", gcnt, GC + 1);
      hcnt = 0;
      gcnt = 0;
    end
  end

  initial
  begin
    #200000;
    fail_count++;
    end_sim();
  end

  // ------
  // Main sequence
  // ------
  initial
  begin
    int i;
    ce = 1'b1;
    rst_i = 1'b1;
    start = 1'b0;
    hmode = 2'h0;
    {ot, op, oh, run_gas, sel} = '0;
    nst = 4'hA;
    gw = '0;
    rh = '0;
    bus2.wr_en = 1'b0;
    bus2.wr_addr = 8'h00;
    bus2.wr_data = 8'h00;
    void'($urandom(32'hAA30));
    repeat (5) @(negedge mclk_i);
    rst_i = 1'b0;
    repeat (20) @(negedge mclk_i);
    check("mode after reset", mode1, GSMS_SLEEP);
    check("heater after reset", {busy1, heat}, 2'h0);
    // Every oversampling code in forced runs
    for (i = 0; i < 8; i++)
    begin
      ot = 3'(i);
      op = 3'($urandom_range(5));
      oh = 3'($urandom_range(5));
      // Period closes one edge after the last phase, hence the extra cycle
      q_per.push_back(16'(ph(ot) + ph(op) + ph(oh) + 1));
      run(GSMS_FORCED);
      wait_idle();
    end
    // Forced gas runs, lowest and highest step
    run_gas = 1'b1;
    for (i = 0; i < 10; i++)
    begin
      gw[i] = {2'b00, 6'($urandom_range(1, 30))};
      rh[i] = 8'($urandom);
    end
    gw[0] = 8'h59;
    for (i = 0; i < 2; i++)
    begin
      sel = i ? 4'h9 : 4'h0;
      q_per.push_back(16'hFFFF);
      q_heat.push_back({sel, rh[sel], 12'(hl(gw[sel]))});
      run(GSMS_FORCED);
      wait_idle();
    end
    // Gas disabled: no heater, plain period
    run_gas = 1'b0;
    q_per.push_back(16'(ph(ot) + ph(op) + ph(oh) + 1));
    run(GSMS_FORCED);
    wait_idle();
    // Parallel three-step profile; sleep written mid-period takes effect when that period ends
    run_gas = 1'b1;
    sel = 4'h2;
    nst = 4'h3;
    {ot, op, oh} = {3'h1, 3'h0, 3'h0};
    gw[0] = 8'h05;
    gw[1] = 8'h43;
    gw[2] = 8'h02;
    for (i = 0; i < 5; i++)
      q_heat.push_back({4'(i % 3), rh[i % 3], 12'(hl(gw[i % 3]))});
    run(GSMS_PARALLEL);
    for (i = 0; i < 4000 && q_heat.size() > 1; i++)
      @(negedge mclk_i);
    check("mode held", mode1, GSMS_PARALLEL);
    run(GSMS_SLEEP);
    wait_idle();
    check("profile finished", q_heat.size(), 0);
    // Probe: second mode write while pending is dropped
    wr2(`GSMS_ADDR_MODE, 8'h01);
    wr2(`GSMS_ADDR_MODE, 8'h02);
    wr2(8'h55, 8'h01);
    wr2(`GSMS_ADDR_MODE, 8'h03);
    wr2(8'h55, 8'h02);
    check("code 3 refused", bus2.pend, 1'b0);
    @(negedge mclk_i);
    bus2.wr_en = 1'b0;
    repeat (20) @(negedge mclk_i);
    check("probe mode", bus2.mode, GSMS_SLEEP);
    check("probe periods", done2, 1);
    end_sim();
  end
endmodule
